// ===== iasr_pkg.sv
// Package of constants and types for the interrupt acceptance and standby control.
package iasr_pkg;
	localparam int RESET_MIN_CLOCKS = 4;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PFP_RESET = 16'h0000;
	localparam logic [15:0] CODE_SEG_RESET = 16'hffff;
	localparam logic [15:0] DATA_SEG_RESET = 16'h0000;
	localparam logic [15:0] FLAG_RESET = 16'h7802;
	localparam logic [7:0] EMU_RESET = 8'h00;
	localparam int FLAG_IE_BIT = 9;
	localparam int FLAG_BRK_BIT = 8;
	localparam logic [2:0] BUS_STATUS_HALT = 3'h3;
	localparam logic BUS_MIO_HALT = 1'h0;
	localparam logic [2:0] BUS_STATUS_IDLE = 3'h7;
	localparam logic [3:0] PSTAT_RESET = 4'h2;
	localparam logic [1:0] QSTAT_RESET = 2'h0;
	localparam logic [2:0] MAX_PREFIX_KINDS = 3'h3;
	localparam logic [2:0] MOVW_EVEN_MAX = 3'h4;
	localparam logic [2:0] MOVW_EO_MAX = 3'h6;
	localparam logic [2:0] MOVW_OE_MAX = 3'h5;
	localparam logic [2:0] MOVW_ODD_MAX = 3'h7;
	localparam logic [2:0] CMP_MAX = 3'h4;
	localparam logic [2:0] STORE_MAX = 3'h5;
	typedef enum logic [1:0] {
		IASR_RUN = 2'b00,
		IASR_STANDBY = 2'b01,
		IASR_SERVICE = 2'b10
	} iasr_state_e;
	typedef enum logic [2:0] {
		IASR_BLK_NONE = 3'b000,
		IASR_BLK_MOVW = 3'b001,
		IASR_BLK_MOVB = 3'b010,
		IASR_BLK_CMP = 3'b011,
		IASR_BLK_STORE = 3'b100
	} iasr_blk_e;
endpackage : iasr_pkg

// ===== iasr_sync.sv
// Two flip-flop synchroniser for one pin level.
`timescale 1ns/100ps
module iasr_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pinIn,
	output logic syncOut
);
	logic meta_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			meta_q <= pinIn;
			syncOut <= meta_q;
		end
	end
endmodule : iasr_sync

// ===== iasr_latency.sv
// Bus cycle counter that bounds interrupt latency inside block instructions.
`timescale 1ns/100ps
module iasr_latency (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic busCycleDone,
	input wire logic [2:0] maxCycles,
	output logic expired
);
	logic [2:0] count_q;
	logic active_q;
	// The cycle in which the request arrives counts as the first.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_q <= 3'h0;
			active_q <= 1'b0;
		end else if (start && !active_q) begin
			count_q <= 3'h1;
			active_q <= 1'b1;
		end else if (!start) begin
			active_q <= 1'b0;
			count_q <= 3'h0;
		end else if (busCycleDone && count_q != 3'h7) begin
			count_q <= count_q + 3'h1;
		end
	end
	assign expired = active_q && (count_q >= maxCycles);
endmodule : iasr_latency

// ===== iasr_ctrl.sv
// Interrupt acceptance, standby and reset control of the processor core.
// What this block does
// RL1 - No hardware or step interrupt right after a segment register move or pop.
// RL2 - No hardware or step interrupt right after any of three prefix kinds.
// RL3 - After the unmask instruction only the maskable interrupt is blocked.
// RL4 - NMI arriving at a blocked boundary is held and taken after next instruction.
// RL5 - Block moves accept interrupts within 2-4 or 3-7 bus cycles by alignment.
// RL6 - Compare, scan and load take 1-4 cycles; stores take 3-5.
// RL7 - Saved return address steps back one byte per prefix kind, up to three.
// RL8 - The halt instruction enters standby and stops execution.
// RL9 - Standby drives halt status and keeps the address strobe low.
// RL10 - Standby ends only on NMI, maskable interrupt or reset.
// RL11 - NMI in standby is serviced, then resumes after the halt.
// RL12 - Enabled maskable interrupt in standby is serviced, then resumes after halt.
// RL13 - Disabled maskable interrupt leaves standby and continues after halt.
// RL14 - The source holds the maskable request 15 clocks to wake with it disabled.
// RL15 - Reset in standby ends standby, clears the held NMI and prefix count and starts a normal reset.
// RL16 - Reset held at least four clocks; pins hold reset states while high.
// RL17 - During reset bus pins float, queue and processor status pins take fixed levels; bus status bits keep their value.
// RL18 - Reset sets counter, pointers, segments, flags and emulation registers.
// RL19 - NMI is rising-edge detected, never masked, and beats the maskable one.
// RL20 - Service pushes flags, segment, counter and clears enable and step flags.
`timescale 1ns/100ps
module iasr_ctrl (
	input wire logic clk,
	input wire logic rstn,
	input wire logic resetPin,
	input wire logic nmiPin,
	input wire logic maskableIrqPin,
	input wire logic instrDone,
	input wire logic instrIsSegMove,
	input wire logic instrIsPrefix,
	input wire logic [1:0] prefixKind,
	input wire logic instrIsUnmask,
	input wire logic instrIsHalt,
	input wire logic instrIsReturn,
	input wire logic [15:0] instrNextPc,
	input wire logic [15:0] instrStartPc,
	input wire logic [2:0] blockKind,
	input wire logic blockSrcOdd,
	input wire logic blockDstOdd,
	input wire logic busCycleDone,
	input wire logic [15:0] retCodeSeg,
	input wire logic [15:0] retPc,
	input wire logic [15:0] retFlags,
	input wire logic [15:0] vectorCodeSeg,
	input wire logic [15:0] vectorPc,
	input wire logic [15:0] flagWrite,
	input wire logic flagWriteEn,
	output logic execEnable,
	output logic irqTake,
	output logic irqTakeNmi,
	output logic irqTakeStep,
	output logic [15:0] pushFlags,
	output logic [15:0] pushCodeSeg,
	output logic [15:0] pushPc,
	output logic [15:0] programCounter,
	output logic [15:0] prefetchPointer,
	output logic [15:0] codeSegmentReg,
	output logic [15:0] stackSegReg,
	output logic [15:0] dataSeg0Reg,
	output logic [15:0] dataSeg1Reg,
	output logic [15:0] flagWord,
	output logic [7:0] emuRegs,
	output logic inStandby,
	output logic [2:0] busStatusBits,
	output logic memoryOrIoN,
	output logic busFloatN,
	output logic addressStrobeOut,
	output logic [1:0] queueStatus,
	output logic [3:0] processorStatusLine,
	output logic irqAcknowledgeN,
	output logic holdGrantOut
);
	////////////////////////////////////////////////////////////////////////
	logic rstSync;
	logic nmiSync;
	logic intSync;
	iasr_sync uRst (.clk(clk), .rstn(rstn), .pinIn(resetPin),
		.syncOut(rstSync));
	iasr_sync uNmi (.clk(clk), .rstn(rstn), .pinIn(nmiPin),
		.syncOut(nmiSync));
	iasr_sync uInt (.clk(clk), .rstn(rstn), .pinIn(maskableIrqPin),
		.syncOut(intSync));

	// Reset acts only after the pin has been high for the minimum count.
	logic [2:0] rstCount_q;
	logic coreReset;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstCount_q <= 3'h0;
		end else if (!rstSync) begin
			rstCount_q <= 3'h0;
		end else if (rstCount_q < 3'(iasr_pkg::RESET_MIN_CLOCKS)) begin
			rstCount_q <= rstCount_q + 3'h1; // see RL16
		end
	end
	assign coreReset = rstSync &&
		(rstCount_q >= 3'(iasr_pkg::RESET_MIN_CLOCKS - 1)); // see RL16

	////////////////////////////////////////////////////////////////////////
	logic nmiPrev_q;
	logic nmiPend_q;
	logic nmiEdge;
	assign nmiEdge = nmiSync && !nmiPrev_q; // see RL19
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nmiPrev_q <= 1'b0;
		end else begin
			nmiPrev_q <= nmiSync;
		end
	end

	// The instruction completing now decides what its own boundary blocks.
	logic blockAll;
	logic blockInt;
	logic [1:0] prefixCount_q;
	logic [2:0] prefixSeen_q;
	logic [2:0] prefixSeen_d;
	logic [1:0] prefixCount_d;
	assign blockAll = instrIsSegMove || instrIsPrefix; // see RL1, RL2
	assign blockInt = instrIsUnmask; // see RL3
	always_comb begin
		prefixSeen_d = prefixSeen_q;
		prefixCount_d = prefixCount_q;
		if (instrIsPrefix && prefixKind != 2'h3 &&
			!prefixSeen_q[prefixKind]) begin
			prefixSeen_d[prefixKind] = 1'b1;
			prefixCount_d = prefixCount_q + 2'h1; // see RL7
		end
	end

	iasr_pkg::iasr_state_e state_q;
	logic inBlock;
	logic [2:0] latMax;
	logic latExpired;
	assign inBlock = (blockKind != iasr_pkg::IASR_BLK_NONE) && !instrDone;
	always_comb begin
		case (blockKind)
			iasr_pkg::IASR_BLK_MOVW: begin
				case ({blockSrcOdd, blockDstOdd})
					2'b00: latMax = iasr_pkg::MOVW_EVEN_MAX; // see RL5
					2'b01: latMax = iasr_pkg::MOVW_EO_MAX;
					2'b10: latMax = iasr_pkg::MOVW_OE_MAX;
					default: latMax = iasr_pkg::MOVW_ODD_MAX; // see RL5
				endcase
			end
			iasr_pkg::IASR_BLK_MOVB: latMax = iasr_pkg::MOVW_EVEN_MAX;
			iasr_pkg::IASR_BLK_CMP: latMax = iasr_pkg::CMP_MAX; // see RL6
			iasr_pkg::IASR_BLK_STORE: latMax = iasr_pkg::STORE_MAX; // see RL6
			default: latMax = 3'h1;
		endcase
	end

	logic [15:0] flagWord_q;
	logic intWant;
	logic nmiWant;
	logic anyWant;
	assign nmiWant = nmiEdge || nmiPend_q;
	assign intWant = intSync && flagWord_q[iasr_pkg::FLAG_IE_BIT];
	assign anyWant = inBlock && (nmiWant || intWant);
	iasr_latency uLat (.clk(clk), .rstn(rstn), .start(anyWant),
		.busCycleDone(busCycleDone), .maxCycles(latMax),
		.expired(latExpired));

	logic boundary;
	logic takeNmi;
	logic takeInt;
	logic takeStep;
	logic takeAny;
	assign boundary = (state_q == iasr_pkg::IASR_RUN) &&
		((instrDone && !blockAll) || latExpired); // see RL1, RL2
	assign takeNmi = boundary && nmiWant; // see RL19
	assign takeInt = boundary && !takeNmi && intWant &&
		!(instrDone && blockInt); // see RL3
	assign takeStep = boundary && !takeNmi && !takeInt && !latExpired &&
		flagWord_q[iasr_pkg::FLAG_BRK_BIT];
	assign takeAny = takeNmi || takeInt || takeStep;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nmiPend_q <= 1'b0;
		end else if (coreReset) begin
			nmiPend_q <= 1'b0;
		end else if (nmiEdge && !takeNmi &&
			state_q != iasr_pkg::IASR_STANDBY) begin
			// An edge in standby wakes the core itself and is not held too.
			nmiPend_q <= 1'b1; // see RL4
		end else if (takeNmi || (state_q == iasr_pkg::IASR_STANDBY)) begin
			nmiPend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prefixSeen_q <= 3'h0;
			prefixCount_q <= 2'h0;
		end else if (coreReset || takeAny) begin
			prefixSeen_q <= 3'h0;
			prefixCount_q <= 2'h0;
		end else if (instrDone) begin
			prefixSeen_q <= instrIsPrefix ? prefixSeen_d : 3'h0;
			prefixCount_q <= instrIsPrefix ? prefixCount_d : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Standby entry, release and service sequencing.
	logic wakeNmi;
	logic wakeInt;
	assign wakeNmi = (state_q == iasr_pkg::IASR_STANDBY) && nmiEdge;
	assign wakeInt = (state_q == iasr_pkg::IASR_STANDBY) && intSync;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= iasr_pkg::IASR_RUN;
		end else if (coreReset) begin
			state_q <= iasr_pkg::IASR_RUN; // see RL15
		end else begin
			case (state_q)
				iasr_pkg::IASR_RUN: begin
					if (takeAny) begin
						state_q <= iasr_pkg::IASR_SERVICE;
					end else if (instrDone && instrIsHalt) begin
						state_q <= iasr_pkg::IASR_STANDBY; // see RL8
					end
				end
				iasr_pkg::IASR_STANDBY: begin
					if (wakeNmi || (wakeInt &&
						flagWord_q[iasr_pkg::FLAG_IE_BIT])) begin
						state_q <= iasr_pkg::IASR_SERVICE; // see RL11, RL12
					end else if (wakeInt) begin
						state_q <= iasr_pkg::IASR_RUN; // see RL13
					end
				end
				iasr_pkg::IASR_SERVICE: state_q <= iasr_pkg::IASR_RUN;
				default: state_q <= iasr_pkg::IASR_RUN;
			endcase
		end
	end

	logic serviceStart;
	logic fromStandby;
	assign fromStandby = (state_q == iasr_pkg::IASR_STANDBY) &&
		(wakeNmi || (wakeInt && flagWord_q[iasr_pkg::FLAG_IE_BIT]));
	assign serviceStart = !coreReset && ((state_q == iasr_pkg::IASR_RUN &&
		takeAny) || fromStandby); // see RL10

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqTake <= 1'b0;
			irqTakeNmi <= 1'b0;
			irqTakeStep <= 1'b0;
			pushFlags <= iasr_pkg::FLAG_RESET;
			pushCodeSeg <= iasr_pkg::CODE_SEG_RESET;
			pushPc <= iasr_pkg::PC_RESET;
		end else begin
			irqTake <= serviceStart;
			irqTakeNmi <= serviceStart && (takeNmi || wakeNmi);
			irqTakeStep <= serviceStart && takeStep;
			if (serviceStart) begin
				pushFlags <= flagWord_q; // see RL20
				pushCodeSeg <= retCodeSeg;
				if (fromStandby) begin
					pushPc <= programCounter; // see RL11, RL12
				end else if (latExpired) begin
					pushPc <= instrStartPc -
						16'(prefixCount_q); // see RL7
				end else begin
					pushPc <= retPc;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Architectural registers with their reset values.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flagWord_q <= iasr_pkg::FLAG_RESET;
		end else if (coreReset) begin
			flagWord_q <= iasr_pkg::FLAG_RESET; // see RL18
		end else if (serviceStart) begin
			flagWord_q[iasr_pkg::FLAG_IE_BIT] <= 1'b0; // see RL20
			flagWord_q[iasr_pkg::FLAG_BRK_BIT] <= 1'b0;
		end else if (instrIsReturn && instrDone) begin
			flagWord_q <= retFlags;
		end else if (flagWriteEn) begin
			flagWord_q <= flagWrite;
		end
	end
	assign flagWord = flagWord_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			programCounter <= iasr_pkg::PC_RESET;
			prefetchPointer <= iasr_pkg::PFP_RESET;
			codeSegmentReg <= iasr_pkg::CODE_SEG_RESET;
			stackSegReg <= iasr_pkg::DATA_SEG_RESET;
			dataSeg0Reg <= iasr_pkg::DATA_SEG_RESET;
			dataSeg1Reg <= iasr_pkg::DATA_SEG_RESET;
			emuRegs <= iasr_pkg::EMU_RESET;
		end else if (coreReset) begin
			programCounter <= iasr_pkg::PC_RESET; // see RL18
			prefetchPointer <= iasr_pkg::PFP_RESET;
			codeSegmentReg <= iasr_pkg::CODE_SEG_RESET;
			stackSegReg <= iasr_pkg::DATA_SEG_RESET;
			dataSeg0Reg <= iasr_pkg::DATA_SEG_RESET;
			dataSeg1Reg <= iasr_pkg::DATA_SEG_RESET;
			emuRegs <= iasr_pkg::EMU_RESET;
		end else if (serviceStart) begin
			programCounter <= vectorPc;
			prefetchPointer <= vectorPc;
			codeSegmentReg <= vectorCodeSeg;
		end else if (instrIsReturn && instrDone) begin
			programCounter <= retPc;
			prefetchPointer <= retPc;
			codeSegmentReg <= retCodeSeg;
		end else if (instrDone && state_q == iasr_pkg::IASR_RUN) begin
			programCounter <= instrNextPc; // see RL13
			prefetchPointer <= instrNextPc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin states for reset, standby and normal running.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			execEnable <= 1'b0;
			inStandby <= 1'b0;
			busStatusBits <= iasr_pkg::BUS_STATUS_IDLE;
			memoryOrIoN <= 1'b1;
			busFloatN <= 1'b0;
			addressStrobeOut <= 1'b0;
			queueStatus <= iasr_pkg::QSTAT_RESET;
			processorStatusLine <= iasr_pkg::PSTAT_RESET;
			irqAcknowledgeN <= 1'b1;
			holdGrantOut <= 1'b0;
		end else if (coreReset) begin
			execEnable <= 1'b0;
			inStandby <= 1'b0;
			busFloatN <= 1'b0; // see RL17
			addressStrobeOut <= 1'b0;
			queueStatus <= iasr_pkg::QSTAT_RESET;
			processorStatusLine <= iasr_pkg::PSTAT_RESET;
			irqAcknowledgeN <= 1'b1;
			holdGrantOut <= 1'b0;
		end else begin
			execEnable <= (state_q == iasr_pkg::IASR_RUN); // see RL8
			inStandby <= (state_q == iasr_pkg::IASR_STANDBY);
			busFloatN <= 1'b1;
			addressStrobeOut <= 1'b0; // see RL9
			if (state_q == iasr_pkg::IASR_STANDBY) begin
				busStatusBits <= iasr_pkg::BUS_STATUS_HALT; // see RL9
				memoryOrIoN <= iasr_pkg::BUS_MIO_HALT;
			end else begin
				busStatusBits <= iasr_pkg::BUS_STATUS_IDLE;
				memoryOrIoN <= 1'b1;
			end
		end
	end
endmodule : iasr_ctrl

// ===== iasr_ctrl_assertions.sv
// Checker of interrupt acceptance, standby and reset pin behaviour.
`timescale 1ns/100ps
module iasr_ctrl_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic resetPin,
	input wire logic nmiPin,
	input wire logic maskableIrqPin,
	input wire logic instrDone,
	input wire logic instrIsSegMove,
	input wire logic instrIsPrefix,
	input wire logic instrIsUnmask,
	input wire logic instrIsHalt,
	input wire logic [15:0] vectorPc,
	input wire logic execEnable,
	input wire logic irqTake,
	input wire logic irqTakeNmi,
	input wire logic irqTakeStep,
	input wire logic [15:0] programCounter,
	input wire logic [15:0] codeSegmentReg,
	input wire logic [15:0] flagWord,
	input wire logic inStandby,
	input wire logic [2:0] busStatusBits,
	input wire logic memoryOrIoN,
	input wire logic busFloatN,
	input wire logic addressStrobeOut,
	input wire logic [1:0] queueStatus,
	input wire logic [3:0] processorStatusLine,
	input wire logic irqAcknowledgeN,
	input wire logic holdGrantOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	a_reset_pin_levels: assert property (resetPin [*8] |->
		!busFloatN && queueStatus == iasr_pkg::QSTAT_RESET && irqAcknowledgeN
		&& processorStatusLine == iasr_pkg::PSTAT_RESET && !addressStrobeOut
		&& !holdGrantOut) else $error("reset pin levels wrong");
	a_reset_reg_values: assert property (resetPin [*8] |->
		programCounter == iasr_pkg::PC_RESET && flagWord == iasr_pkg::FLAG_RESET
		&& codeSegmentReg == iasr_pkg::CODE_SEG_RESET)
		else $error("reset register values wrong");
	a_standby_halt_status: assert property (inStandby |->
		busStatusBits == iasr_pkg::BUS_STATUS_HALT && !execEnable
		&& memoryOrIoN == iasr_pkg::BUS_MIO_HALT && !addressStrobeOut)
		else $error("standby status wrong");
	a_halt_enters_standby: assert property (instrDone && instrIsHalt
		&& execEnable && !resetPin && !nmiPin && !maskableIrqPin
		|-> ##[1:3] inStandby) else $error("halt did not enter standby");
	a_standby_stays: assert property ((inStandby && !nmiPin
		&& !maskableIrqPin && !resetPin) [*5] |=> inStandby)
		else $error("standby left without cause");
	a_take_clears_flags: assert property (irqTake |->
		!flagWord[iasr_pkg::FLAG_IE_BIT] && !flagWord[iasr_pkg::FLAG_BRK_BIT]
		&& programCounter == vectorPc) else $error("service entry wrong");
	a_seg_blocks_take: assert property (instrDone
		&& (instrIsSegMove || instrIsPrefix) |=> !irqTake)
		else $error("take after segment move or prefix");
	a_unmask_blocks_int: assert property (instrDone && instrIsUnmask |=>
		!irqTake || irqTakeNmi || irqTakeStep)
		else $error("maskable take after unmask");
	a_take_single_pulse: assert property (irqTake |=> !irqTake)
		else $error("take longer than one cycle");
	c_nmi_take: cover property (irqTake && irqTakeNmi);
	c_int_take: cover property (irqTake && !irqTakeNmi);
	c_standby_exit: cover property ($fell(inStandby));
endmodule : iasr_ctrl_assertions
bind iasr_ctrl iasr_ctrl_assertions i_iasr_ctrl_assertions (.clk, .rstn,
	.resetPin, .nmiPin, .maskableIrqPin, .instrDone, .instrIsSegMove,
	.instrIsPrefix, .instrIsUnmask, .instrIsHalt, .vectorPc, .execEnable,
	.irqTake, .irqTakeNmi, .irqTakeStep, .programCounter, .codeSegmentReg,
	.flagWord, .inStandby, .busStatusBits, .memoryOrIoN, .busFloatN,
	.addressStrobeOut, .queueStatus, .processorStatusLine, .irqAcknowledgeN,
	.holdGrantOut);

// ===== iasr_irq_source.sv
// Model of the interrupt source and bus logic beside the core.
`timescale 1ns/100ps
module iasr_irq_source (
	input wire logic clk,
	input wire logic rstn,
	input wire logic nmiReq,
	input wire logic intReq,
	input wire logic busRun,
	output logic nmiPin,
	output logic maskableIrqPin,
	output logic busCycleDone
);
	logic [3:0] nmiCnt_q;
	logic [4:0] intCnt_q;
	logic [1:0] busCnt_q;
	// An NMI request becomes a pulse of eight clocks.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) nmiCnt_q <= 4'h0;
		else if (nmiReq) nmiCnt_q <= 4'h8;
		else if (nmiCnt_q != 4'h0) nmiCnt_q <= nmiCnt_q - 4'h1;
	end
	// A raised maskable request stays up 15 clocks after it is dropped.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) intCnt_q <= 5'h00;
		else if (intReq) intCnt_q <= 5'h0f;
		else if (intCnt_q != 5'h00) intCnt_q <= intCnt_q - 5'h01;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) busCnt_q <= 2'h0;
		else if (busRun) busCnt_q <= busCnt_q + 2'h1;
	end
	assign nmiPin = nmiCnt_q != 4'h0;
	assign maskableIrqPin = intReq || intCnt_q != 5'h00;
	assign busCycleDone = busRun && busCnt_q == 2'h3;
endmodule : iasr_irq_source

// ===== iasr_ctrl_tb.sv
// Self-checking testbench of the interrupt acceptance and standby control.
`timescale 1ns/100ps
module iasr_ctrl_tb;
	logic clk, rstn, resetPin, nmiPin, maskableIrqPin, instrDone, busCycleDone;
	logic instrIsSegMove, instrIsPrefix, instrIsUnmask, instrIsHalt;
	logic blockSrcOdd, blockDstOdd, flagWriteEn, nmiReq, intReq, busRun;
	logic irqTake, irqTakeNmi, inStandby, busFloatN, instrIsReturn;
	logic [1:0] prefixKind;
	logic [2:0] blockKind, busStatusBits;
	logic [15:0] instrNextPc, instrStartPc, retPc, flagWrite, pushFlags;
	logic [15:0] pushPc, programCounter, codeSegmentReg, flagWord;
	int badCount, samplesChecked, n;
	iasr_ctrl i_iasr_ctrl (.clk, .rstn, .resetPin, .nmiPin, .maskableIrqPin,
		.instrDone, .instrIsSegMove, .instrIsPrefix, .prefixKind,
		.instrIsUnmask, .instrIsHalt, .instrIsReturn, .instrNextPc,
		.instrStartPc, .blockKind, .blockSrcOdd, .blockDstOdd, .busCycleDone,
		.retCodeSeg(16'h2000), .retPc, .retFlags(iasr_pkg::FLAG_RESET),
		.vectorCodeSeg(16'h0800), .vectorPc(16'h0480), .flagWrite,
		.flagWriteEn, .execEnable(), .irqTake, .irqTakeNmi, .irqTakeStep(),
		.pushFlags, .pushCodeSeg(), .pushPc, .programCounter,
		.prefetchPointer(), .codeSegmentReg, .stackSegReg(), .dataSeg0Reg(),
		.dataSeg1Reg(), .flagWord, .emuRegs(), .inStandby, .busStatusBits,
		.memoryOrIoN(), .busFloatN, .addressStrobeOut(), .queueStatus(),
		.processorStatusLine(), .irqAcknowledgeN(), .holdGrantOut());
	iasr_irq_source i_iasr_irq_source (.clk, .rstn, .nmiReq, .intReq, .busRun,
		.nmiPin, .maskableIrqPin, .busCycleDone);
	////////////////////////////////////////////////////////////////////////
	task automatic step(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
		samplesChecked++;
		if (s !== e) begin
			badCount++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask : chk
	task automatic instr(input logic seg, input logic [1:0] pk, input logic unm, input logic hlt);
		{instrIsSegMove, prefixKind, instrIsUnmask, instrIsHalt} = {seg, pk, unm, hlt};
		instrIsPrefix = pk != 2'h3;
		instrDone = 1'b1;
		step();
		instrDone = 1'b0;
	endtask : instr
	task automatic waitTake(input int lim);
		for (n = 0; n < lim && irqTake !== 1'b1; n++) step();
	endtask : waitTake
	task automatic setIe();
		flagWrite = iasr_pkg::FLAG_RESET | (16'h0001 << iasr_pkg::FLAG_IE_BIT);
		flagWriteEn = 1'b1;
		step();
		flagWriteEn = 1'b0;
	endtask : setIe
	task automatic t_nmi_held(input logic seg, input logic [1:0] pk);
		retPc = 16'h0210;
		nmiReq = 1'b1;
		step();
		nmiReq = 1'b0;
		step(4);
		instr(seg, pk, 1'b0, 1'b0);
		step();
		chk("blocked take", 16'h0, 16'(irqTake));
		instr(1'b0, 2'h3, 1'b0, 1'b0);
		waitTake(4);
		chk("held nmi take", 16'h1, 16'(irqTakeNmi));
		chk("pushed pc", 16'h0210, pushPc);
		chk("pushed flags", iasr_pkg::FLAG_RESET, pushFlags);
		step(10);
	endtask : t_nmi_held
	task automatic t_unmask();
		setIe();
		intReq = 1'b1;
		step(4);
		instr(1'b0, 2'h3, 1'b1, 1'b0);
		step();
		chk("take after unmask", 16'h0, 16'(irqTake));
		instr(1'b0, 2'h3, 1'b0, 1'b0);
		waitTake(4);
		chk("maskable take", 16'h1, 16'({irqTake, irqTakeNmi} == 2'b10));
		intReq = 1'b0;
		step(20);
	endtask : t_unmask
	task automatic t_block(input logic [2:0] kd, input logic so, input logic dOdd,
		input logic [2:0] mx, input int npre);
		int cnt;
		setIe();
		for (int i = 0; i < npre; i++) begin
			instr(1'b0, 2'(2 - i), 1'b0, 1'b0);
			step();
		end
		{blockKind, blockSrcOdd, blockDstOdd} = {kd, so, dOdd};
		instrStartPc = 16'h0100;
		retPc = 16'h0100;
		busRun = 1'b1;
		intReq = 1'b1;
		cnt = 1;
		for (n = 0; n < 60 && irqTake !== 1'b1; n++) begin
			step();
			// The first two edges belong to the pin synchroniser.
			if (busCycleDone && n >= 2) cnt++;
		end
		chk("block latency", 16'h1, 16'(irqTake === 1'b1 && cnt <= mx));
		chk("block resume", 16'h0100 - 16'(npre), pushPc);
		{intReq, busRun, blockKind} = 5'h00;
		step(20);
	endtask : t_block
	task automatic t_halt_nmi();
		instrNextPc = 16'h1234;
		retPc = 16'h1234;
		instr(1'b0, 2'h3, 1'b0, 1'b1);
		step(12);
		chk("standby", 16'h1, 16'(inStandby));
		chk("halt status", 16'(iasr_pkg::BUS_STATUS_HALT), 16'(busStatusBits));
		nmiReq = 1'b1;
		step();
		nmiReq = 1'b0;
		waitTake(10);
		chk("nmi wake", 16'h1, 16'(irqTakeNmi));
		chk("resume pc", 16'h1234, pushPc);
		instrIsReturn = 1'b1;
		instr(1'b0, 2'h3, 1'b0, 1'b0);
		instrIsReturn = 1'b0;
		chk("return pc", 16'h1234, programCounter);
		step(12);
	endtask : t_halt_nmi
	task automatic t_halt_int_off();
		logic seen;
		seen = 1'b0;
		instrNextPc = 16'h2346;
		instr(1'b0, 2'h3, 1'b0, 1'b1);
		step(4);
		intReq = 1'b1;
		step();
		intReq = 1'b0;
		for (n = 0; n < 20 && inStandby !== 1'b0; n++) begin
			step();
			seen |= irqTake;
		end
		chk("woken", 16'h0, 16'(inStandby));
		chk("no service", 16'h0, 16'(seen));
		chk("resume pc", 16'h2346, programCounter);
		step(20);
	endtask : t_halt_int_off
	task automatic t_reset_standby();
		instr(1'b0, 2'h3, 1'b0, 1'b1);
		step(3);
		resetPin = 1'b1;
		step(8);
		chk("standby after reset", 16'h0, 16'(inStandby));
		chk("bus float", 16'h0, 16'(busFloatN));
		chk("flags", iasr_pkg::FLAG_RESET, flagWord);
		chk("code segment", iasr_pkg::CODE_SEG_RESET, codeSegmentReg);
		chk("pc", iasr_pkg::PC_RESET, programCounter);
		resetPin = 1'b0;
		step(6);
	endtask : t_reset_standby
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rstn, resetPin, instrDone, instrIsSegMove, instrIsPrefix} = 5'h00;
		{instrIsUnmask, instrIsHalt, instrIsReturn} = 3'h0;
		{blockSrcOdd, blockDstOdd} = 2'h0;
		{flagWriteEn, nmiReq, intReq, busRun, prefixKind, blockKind} = 9'h018;
		{instrNextPc, instrStartPc, retPc, flagWrite} = 64'h0;
		blockKind = 3'h0;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		step(4);
		t_nmi_held(1'b1, 2'h3);
		for (int k = 0; k < 3; k++) t_nmi_held(1'b0, 2'(k));
		t_unmask();
		t_block(iasr_pkg::IASR_BLK_MOVW, 1'b0, 1'b0, iasr_pkg::MOVW_EVEN_MAX, 3);
		t_block(iasr_pkg::IASR_BLK_MOVW, 1'b1, 1'b1, iasr_pkg::MOVW_ODD_MAX, 1);
		t_block(iasr_pkg::IASR_BLK_MOVB, 1'b0, 1'b0, 3'h4, 2);
		t_block(iasr_pkg::IASR_BLK_CMP, 1'b1, 1'b1, iasr_pkg::CMP_MAX, 0);
		t_block(iasr_pkg::IASR_BLK_STORE, 1'b0, 1'b1, iasr_pkg::STORE_MAX, 0);
		t_halt_nmi();
		t_halt_int_off();
		t_reset_standby();
		wrap_up();
	end
	initial begin
		#20000;
		badCount++;
		wrap_up();
	end
endmodule : iasr_ctrl_tb
